// file: inc/ctl_exc_pkg.sv
// Purpose: shared constants and types of the control instruction unit
// Assumes: 32-bit data path, 5-bit register and control indices
// Notes:   control indices, status fields and software offsets are fixed here
package ctl_exc_pkg;
  localparam int DATA_W    = 32;
  localparam int REG_IDX_W = 5;
  localparam int CTL_IDX_W = 5;
  localparam int CI_N_W    = 8;

  // control instruction classes handed in by the decoder
  typedef enum logic [4:0] {
    op_nop, op_trap, op_eret, op_break, op_bret, op_rdctl, op_wrctl,
    op_flushd, op_flushda, op_flushi, op_initd, op_initda, op_initi,
    op_flushp, op_sync, op_rdprs, op_wrprs, op_custom,
    op_mul, op_muli, op_mulxss, op_mulxsu, op_mulxuu, op_div, op_divu
  } op_t;

  typedef enum logic [2:0] {
    cache_none, cache_flushd, cache_flushda, cache_flushi,
    cache_initd, cache_initda, cache_initi
  } cache_op_t;

  // control register indices
  localparam logic [CTL_IDX_W-1:0] CTL_STATUS  = 5'h00;
  localparam logic [CTL_IDX_W-1:0] CTL_ESTATUS = 5'h01;
  localparam logic [CTL_IDX_W-1:0] CTL_BSTATUS = 5'h02;
  localparam logic [CTL_IDX_W-1:0] CTL_RET_ADDR = 5'h03;
  localparam logic [CTL_IDX_W-1:0] CTL_BA      = 5'h04;

  // status fields
  localparam int STATUS_PIE_BIT = 0;
  localparam int STATUS_U_BIT   = 1;
  localparam int STATUS_PRS_LSB = 16;
  localparam logic [DATA_W-1:0] STATUS_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] ZERO_WORD  = 32'h0000_0000;

  // software port
  localparam int REG_ADDR_W = 8;
  localparam logic [REG_ADDR_W-1:0] REG_SUPPORT    = 8'h00;
  localparam logic [REG_ADDR_W-1:0] REG_STATE      = 8'h04;
  localparam logic [REG_ADDR_W-1:0] REG_UNIMPL_CNT = 8'h08;
  localparam int UNIMPL_SLOTS = 8;
  localparam logic [UNIMPL_SLOTS-1:0] SUPPORT_RST = 8'hFF;
  localparam int CNT_W   = 16;
  localparam int STATE_W = 3;
endpackage

// file: src/shadow_set_file.sv
// Purpose: general register storage of all register sets
// Assumes: one registered read port, one write port, same clock
// Notes:   contents are not reset; register zero is stored like any other
`timescale 1ns/1ns
module shadow_set_file #(
  parameter int NUM_SETS = 2,
  parameter int SET_W    = 1
) (
  input  wire logic                                core_clk_in,
  input  wire logic                                rd_en_in,
  input  wire logic [SET_W-1:0]                    rd_set_in,
  input  wire logic [ctl_exc_pkg::REG_IDX_W-1:0]   rd_idx_in,
  output logic      [ctl_exc_pkg::DATA_W-1:0]      rd_data_out,
  input  wire logic                                wr_en_in,
  input  wire logic [SET_W-1:0]                    wr_set_in,
  input  wire logic [ctl_exc_pkg::REG_IDX_W-1:0]   wr_idx_in,
  input  wire logic [ctl_exc_pkg::DATA_W-1:0]      wr_data_in
);
  localparam int WORDS = NUM_SETS * (1 << ctl_exc_pkg::REG_IDX_W);
  localparam int AW    = SET_W + ctl_exc_pkg::REG_IDX_W;

  logic [ctl_exc_pkg::DATA_W-1:0] mem [WORDS];
  wire  [AW-1:0]                  rd_addr = {rd_set_in, rd_idx_in};
  wire  [AW-1:0]                  wr_addr = {wr_set_in, wr_idx_in};

  always_ff @(posedge core_clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr] <= wr_data_in;
    end
    if (rd_en_in) begin
      rd_data_out <= mem[rd_addr];
    end
  end
endmodule // shadow_set_file

// file: src/ctl_exc_unit.sv
// Purpose: executes control instructions and raises unimplemented traps
// Assumes: decoder issues one classified instruction while busy_out is low
// Notes:   arithmetic of supported multiply/divide is forwarded elsewhere
// Behaviour
// - trap copies status into saved-status register.
// - trap stores its return address into the exception return register.
// - trap then redirects fetch to the general exception handler.
// - exception return restores status and resumes at saved return address.
// - break and break-return enter and leave debug break processing.
// - control read copies control to general register; write does reverse.
// - six cache maintenance operations are issued to the caches.
// - prefetch flush discards prefetched instructions and refetches.
// - barrier holds later loads and stores until earlier operations finish.
// - other-set read and write move values between register sets.
// - register zero of a shadow set is writable and never assumed zero.
// - custom opcode is handed to user logic whose result is written back.
// - unsupported instruction traps as unimplemented instead of running.
// - only multiply, multiply-high, divide and initda may raise it.
// - every other instruction never raises the unimplemented exception.
// - unimplemented exception is raised even inside an exception handler.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ns
module ctl_exc_unit #(
  parameter int                               NUM_SETS = 2,
  parameter logic [ctl_exc_pkg::DATA_W-1:0]   EXC_ADDR = 32'h0000_0020,
  parameter logic [ctl_exc_pkg::DATA_W-1:0]   BRK_ADDR = 32'h0000_0040
) (
  input  wire logic                               core_clk_in,
  input  wire logic                               rst_b_in,
  input  wire logic                               issue_in,
  input  wire ctl_exc_pkg::op_t                   op_in,
  input  wire logic [ctl_exc_pkg::CTL_IDX_W-1:0]  ctl_idx_in,
  input  wire logic [ctl_exc_pkg::REG_IDX_W-1:0]  dest_idx_in,
  input  wire logic [ctl_exc_pkg::REG_IDX_W-1:0]  src_idx_in,
  input  wire logic [ctl_exc_pkg::DATA_W-1:0]     opnd_a_in,
  input  wire logic [ctl_exc_pkg::DATA_W-1:0]     opnd_b_in,
  input  wire logic [ctl_exc_pkg::DATA_W-1:0]     next_pc_in,
  input  wire logic [ctl_exc_pkg::CI_N_W-1:0]     ci_sel_in,
  output logic                                    busy_out,
  output logic                                    done_out,
  output logic                                    wb_valid_out,
  output logic      [ctl_exc_pkg::REG_IDX_W-1:0]  wb_dest_out,
  output logic      [ctl_exc_pkg::DATA_W-1:0]     wb_data_out,
  output logic                                    redirect_out,
  output logic      [ctl_exc_pkg::DATA_W-1:0]     redirect_addr_out,
  output logic                                    prefetch_flush_out,
  output logic                                    arith_fwd_out,
  output logic      [ctl_exc_pkg::DATA_W-1:0]     status_out,
  input  wire logic                               mem_pending_in,
  output logic                                    mem_hold_out,
  output logic                                    cache_req_out,
  output ctl_exc_pkg::cache_op_t                  cache_kind_out,
  output logic      [ctl_exc_pkg::DATA_W-1:0]     cache_addr_out,
  input  wire logic                               cache_ack_in,
  output logic                                    ci_start_out,
  output logic      [ctl_exc_pkg::CI_N_W-1:0]     ci_sel_out,
  output logic      [ctl_exc_pkg::DATA_W-1:0]     ci_dataa_out,
  output logic      [ctl_exc_pkg::DATA_W-1:0]     ci_datab_out,
  input  wire logic                               ci_done_in,
  input  wire logic [ctl_exc_pkg::DATA_W-1:0]     ci_result_in,
  input  wire logic [ctl_exc_pkg::REG_ADDR_W-1:0] reg_addr_in,
  input  wire logic [ctl_exc_pkg::DATA_W-1:0]     reg_wdata_in,
  input  wire logic                               reg_wr_in,
  input  wire logic                               reg_rd_in,
  output logic      [ctl_exc_pkg::DATA_W-1:0]     reg_rdata_out
);
  localparam int SET_W = (NUM_SETS > 1) ? $clog2(NUM_SETS) : 1;
  localparam int DW    = ctl_exc_pkg::DATA_W;

  if (NUM_SETS < 2 || NUM_SETS > 64) begin : g_chk
    $error("NUM_SETS must lie between 2 and 64");
  end

  typedef enum logic [ctl_exc_pkg::STATE_W-1:0] {
    s_idle, s_cache_wait, s_sync_wait, s_prs_wait, s_ci_wait
  } state_t;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // {valid, slot} of the instructions that may lack hardware
  function automatic logic [3:0] unimpl_slot(ctl_exc_pkg::op_t op);
    case (op)
      ctl_exc_pkg::op_mul:    unimpl_slot = 4'h8;
      ctl_exc_pkg::op_muli:   unimpl_slot = 4'h9;
      ctl_exc_pkg::op_mulxss: unimpl_slot = 4'hA;
      ctl_exc_pkg::op_mulxsu: unimpl_slot = 4'hB;
      ctl_exc_pkg::op_mulxuu: unimpl_slot = 4'hC;
      ctl_exc_pkg::op_div:    unimpl_slot = 4'hD;
      ctl_exc_pkg::op_divu:   unimpl_slot = 4'hE;
      ctl_exc_pkg::op_initda: unimpl_slot = 4'hF;
      default:                unimpl_slot = 4'h0;
    endcase
  endfunction

  function automatic ctl_exc_pkg::cache_op_t cache_kind(ctl_exc_pkg::op_t op);
    case (op)
      ctl_exc_pkg::op_flushd:  cache_kind = ctl_exc_pkg::cache_flushd;
      ctl_exc_pkg::op_flushda: cache_kind = ctl_exc_pkg::cache_flushda;
      ctl_exc_pkg::op_flushi:  cache_kind = ctl_exc_pkg::cache_flushi;
      ctl_exc_pkg::op_initd:   cache_kind = ctl_exc_pkg::cache_initd;
      ctl_exc_pkg::op_initda:  cache_kind = ctl_exc_pkg::cache_initda;
      ctl_exc_pkg::op_initi:   cache_kind = ctl_exc_pkg::cache_initi;
      default:                 cache_kind = ctl_exc_pkg::cache_none;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  state_t                                state_r, state_nxt;
  logic [DW-1:0]                         status_r, status_nxt;
  logic [DW-1:0]                         estatus_r, estatus_nxt;
  logic [DW-1:0]                         bstatus_r, bstatus_nxt;
  logic [DW-1:0]                         exception_return_addr_reg;
  logic [DW-1:0]                         ret_addr_nxt;
  logic [DW-1:0]                         ba_r, ba_nxt;
  logic [ctl_exc_pkg::UNIMPL_SLOTS-1:0]  support_r;
  logic [ctl_exc_pkg::CNT_W-1:0]         unimpl_cnt_r;
  logic [2:0]                            last_slot_r;
  logic [ctl_exc_pkg::REG_IDX_W-1:0]     dest_r;
  logic [DW-1:0]                         ctl_rd_data;
  logic [DW-1:0]                         prs_rd_data;
  logic [DW-1:0]                         reg_rd_mux;

  wire accept     = issue_in && (state_r == s_idle);
  wire [3:0] slot = unimpl_slot(op_in);
  wire take_unimpl = accept && slot[3] && !support_r[slot[2:0]];
  wire fwd_arith  = accept && slot[3] && support_r[slot[2:0]] &&
                    (op_in != ctl_exc_pkg::op_initda);
  wire kind_valid = cache_kind(op_in) != ctl_exc_pkg::cache_none;
  wire cache_go   = accept && kind_valid && !take_unimpl;
  wire trap_go    = accept && (op_in == ctl_exc_pkg::op_trap);
  wire eret_go    = accept && (op_in == ctl_exc_pkg::op_eret);
  wire brk_go     = accept && (op_in == ctl_exc_pkg::op_break);
  wire bret_go    = accept && (op_in == ctl_exc_pkg::op_bret);
  wire flushp_go  = accept && (op_in == ctl_exc_pkg::op_flushp);
  wire rdctl_go   = accept && (op_in == ctl_exc_pkg::op_rdctl);
  wire wrctl_go   = accept && (op_in == ctl_exc_pkg::op_wrctl);
  wire rdprs_go   = accept && (op_in == ctl_exc_pkg::op_rdprs);
  wire wrprs_go   = accept && (op_in == ctl_exc_pkg::op_wrprs);
  wire ci_go      = accept && (op_in == ctl_exc_pkg::op_custom);
  wire sync_go    = accept && (op_in == ctl_exc_pkg::op_sync);
  wire [SET_W-1:0] prev_set = status_r[ctl_exc_pkg::STATUS_PRS_LSB +: SET_W];

  // status on exception or break entry: interrupts off, supervisor mode
  wire [DW-1:0] entry_status = status_r &
    ~((DW'(1) << ctl_exc_pkg::STATUS_PIE_BIT) |
      (DW'(1) << ctl_exc_pkg::STATUS_U_BIT));

  wire single_done = accept && !cache_go && !sync_go && !rdprs_go && !ci_go;
  wire redirect_go = trap_go || take_unimpl || eret_go || brk_go ||
                     bret_go || flushp_go;

  wire [DW-1:0] redirect_addr =
    (trap_go || take_unimpl) ? EXC_ADDR :
    eret_go                  ? exception_return_addr_reg :
    brk_go                   ? BRK_ADDR :
    bret_go                  ? ba_r :
                               next_pc_in;

  always_comb begin
    case (ctl_idx_in)
      ctl_exc_pkg::CTL_STATUS:  ctl_rd_data = status_r;
      ctl_exc_pkg::CTL_ESTATUS: ctl_rd_data = estatus_r;
      ctl_exc_pkg::CTL_BSTATUS: ctl_rd_data = bstatus_r;
      ctl_exc_pkg::CTL_RET_ADDR: ctl_rd_data = exception_return_addr_reg;
      ctl_exc_pkg::CTL_BA:      ctl_rd_data = ba_r;
      default:                  ctl_rd_data = ctl_exc_pkg::ZERO_WORD;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register next values

  always_comb begin
    status_nxt  = status_r;
    estatus_nxt = estatus_r;
    bstatus_nxt = bstatus_r;
    ret_addr_nxt = exception_return_addr_reg;
    ba_nxt      = ba_r;
    if (trap_go || take_unimpl) begin
      estatus_nxt = status_r;
      ret_addr_nxt = next_pc_in;
      status_nxt  = entry_status;
    end else if (eret_go) begin
      status_nxt = estatus_r;
    end else if (brk_go) begin
      bstatus_nxt = status_r;
      ba_nxt      = next_pc_in;
      status_nxt  = entry_status;
    end else if (bret_go) begin
      status_nxt = bstatus_r;
    end else if (wrctl_go) begin
      case (ctl_idx_in)
        ctl_exc_pkg::CTL_STATUS:  status_nxt  = opnd_a_in;
        ctl_exc_pkg::CTL_ESTATUS: estatus_nxt = opnd_a_in;
        ctl_exc_pkg::CTL_BSTATUS: bstatus_nxt = opnd_a_in;
        ctl_exc_pkg::CTL_RET_ADDR: ret_addr_nxt = opnd_a_in;
        ctl_exc_pkg::CTL_BA:      ba_nxt      = opnd_a_in;
        default:                  status_nxt  = status_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      s_idle: begin
        if (cache_go) begin
          state_nxt = s_cache_wait;
        end else if (sync_go) begin
          state_nxt = s_sync_wait;
        end else if (rdprs_go) begin
          state_nxt = s_prs_wait;
        end else if (ci_go) begin
          state_nxt = s_ci_wait;
        end
      end
      s_cache_wait: if (cache_ack_in) begin
        state_nxt = s_idle;
      end
      s_sync_wait: if (!mem_pending_in) begin
        state_nxt = s_idle;
      end
      s_prs_wait: state_nxt = s_idle;
      s_ci_wait: if (ci_done_in) begin
        state_nxt = s_idle;
      end
      default: state_nxt = s_idle;
    endcase
  end

  wire cache_fin = (state_r == s_cache_wait) && cache_ack_in;
  wire sync_fin  = (state_r == s_sync_wait) && !mem_pending_in;
  wire prs_fin   = (state_r == s_prs_wait);
  wire ci_fin    = (state_r == s_ci_wait) && ci_done_in;

  wire          wb_go   = rdctl_go || prs_fin || ci_fin;
  wire [DW-1:0] wb_data = rdctl_go ? ctl_rd_data :
                          prs_fin  ? prs_rd_data :
                                     ci_result_in;

  shadow_set_file #(
    .NUM_SETS (NUM_SETS),
    .SET_W    (SET_W)
  ) u_sets (
    .core_clk_in (core_clk_in),
    .rd_en_in    (rdprs_go),
    .rd_set_in   (prev_set),
    .rd_idx_in   (src_idx_in),
    .rd_data_out (prs_rd_data),
    .wr_en_in    (wrprs_go),
    .wr_set_in   (prev_set),
    .wr_idx_in   (dest_idx_in),
    .wr_data_in  (opnd_a_in)
  );

  ////////////////////////////////////////////////////////////////////////////
  // software port

  always_comb begin
    case (reg_addr_in)
      ctl_exc_pkg::REG_SUPPORT:
        reg_rd_mux = DW'(support_r);
      ctl_exc_pkg::REG_STATE:
        reg_rd_mux = DW'({last_slot_r, 1'b0, state_r});
      ctl_exc_pkg::REG_UNIMPL_CNT:
        reg_rd_mux = DW'(unimpl_cnt_r);
      default:
        reg_rd_mux = ctl_exc_pkg::ZERO_WORD;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      support_r     <= ctl_exc_pkg::SUPPORT_RST;
      reg_rdata_out <= ctl_exc_pkg::ZERO_WORD;
    end else begin
      if (reg_wr_in && reg_addr_in == ctl_exc_pkg::REG_SUPPORT) begin
        support_r <= reg_wdata_in[ctl_exc_pkg::UNIMPL_SLOTS-1:0];
      end
      reg_rdata_out <= reg_rd_in ? reg_rd_mux : ctl_exc_pkg::ZERO_WORD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_r                   <= s_idle;
      status_r                  <= ctl_exc_pkg::STATUS_RST;
      estatus_r                 <= ctl_exc_pkg::STATUS_RST;
      bstatus_r                 <= ctl_exc_pkg::STATUS_RST;
      exception_return_addr_reg <= ctl_exc_pkg::ZERO_WORD;
      ba_r                      <= ctl_exc_pkg::ZERO_WORD;
      unimpl_cnt_r              <= '0;
      last_slot_r               <= 3'h0;
      dest_r                    <= '0;
    end else begin
      state_r                   <= state_nxt;
      status_r                  <= status_nxt;
      estatus_r                 <= estatus_nxt;
      bstatus_r                 <= bstatus_nxt;
      exception_return_addr_reg <= ret_addr_nxt;
      ba_r                      <= ba_nxt;
      if (take_unimpl) begin
        unimpl_cnt_r <= unimpl_cnt_r + 1'b1;
        last_slot_r  <= slot[2:0];
      end
      if (accept) begin
        dest_r <= dest_idx_in;
      end
    end
  end

  // registered outputs toward the pipeline
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      busy_out           <= 1'b0;
      done_out           <= 1'b0;
      wb_valid_out       <= 1'b0;
      wb_dest_out        <= '0;
      wb_data_out        <= ctl_exc_pkg::ZERO_WORD;
      redirect_out       <= 1'b0;
      redirect_addr_out  <= ctl_exc_pkg::ZERO_WORD;
      prefetch_flush_out <= 1'b0;
      arith_fwd_out      <= 1'b0;
      status_out         <= ctl_exc_pkg::STATUS_RST;
      mem_hold_out       <= 1'b0;
    end else begin
      busy_out           <= state_nxt != s_idle;
      done_out           <= single_done || cache_fin || sync_fin ||
                            prs_fin || ci_fin;
      wb_valid_out       <= wb_go;
      wb_dest_out        <= rdctl_go ? dest_idx_in : dest_r;
      wb_data_out        <= wb_go ? wb_data : wb_data_out;
      redirect_out       <= redirect_go;
      redirect_addr_out  <= redirect_go ? redirect_addr : redirect_addr_out;
      prefetch_flush_out <= redirect_go;
      arith_fwd_out      <= fwd_arith;
      status_out         <= status_nxt;
      mem_hold_out       <= (state_nxt == s_sync_wait);
    end
  end

  // registered outputs toward caches and custom logic
  always_ff @(posedge core_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cache_req_out  <= 1'b0;
      cache_kind_out <= ctl_exc_pkg::cache_none;
      cache_addr_out <= ctl_exc_pkg::ZERO_WORD;
      ci_start_out   <= 1'b0;
      ci_sel_out     <= '0;
      ci_dataa_out   <= ctl_exc_pkg::ZERO_WORD;
      ci_datab_out   <= ctl_exc_pkg::ZERO_WORD;
    end else begin
      cache_req_out <= (state_nxt == s_cache_wait);
      if (cache_go) begin
        cache_kind_out <= cache_kind(op_in);
        cache_addr_out <= opnd_a_in;
      end
      ci_start_out <= ci_go;
      if (ci_go) begin
        ci_sel_out   <= ci_sel_in;
        ci_dataa_out <= opnd_a_in;
        ci_datab_out <= opnd_b_in;
      end
    end
  end
endmodule // ctl_exc_unit

// file: test/ctl_exc_props.sv
// Purpose: port assertions of the control instruction unit
// Assumes: one clock, reset active low
// Notes:   bound into the unit below
`timescale 1ns/1ns
module ctl_exc_props #(
  parameter logic [31:0] EXC_ADDR = 32'h0000_0020
) (
  input wire logic             core_clk_in,
  input wire logic             rst_b_in,
  input wire logic             issue_in,
  input wire ctl_exc_pkg::op_t op_in,
  input wire logic             busy_out,
  input wire logic             done_out,
  input wire logic             wb_valid_out,
  input wire logic             redirect_out,
  input wire logic [31:0]      redirect_addr_out,
  input wire logic             prefetch_flush_out,
  input wire logic [31:0]      status_out,
  input wire logic             mem_pending_in,
  input wire logic             mem_hold_out,
  input wire logic             ci_done_in
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_b_in);
  wire tk_w     = issue_in && !busy_out;
  wire trap_w   = tk_w && op_in == ctl_exc_pkg::op_trap;
  wire flushp_w = tk_w && op_in == ctl_exc_pkg::op_flushp;
  wire sync_w   = tk_w && op_in == ctl_exc_pkg::op_sync;
  wire rdprs_w  = tk_w && op_in == ctl_exc_pkg::op_rdprs;
  wire plain_w  = tk_w && op_in inside {ctl_exc_pkg::op_nop,
    ctl_exc_pkg::op_rdctl, ctl_exc_pkg::op_wrctl, ctl_exc_pkg::op_wrprs};
  ////////////////////////////////////////////////////////////////////////////
  property p_trap_vec; trap_w |=> redirect_addr_out == EXC_ADDR; endproperty
  a_trap_vec: assert property (p_trap_vec) else $error("trap vector");
  property p_trap_st; trap_w |=> status_out == ($past(status_out) & ~32'h3);
  endproperty
  a_trap_st: assert property (p_trap_st) else $error("trap status");
  property p_flushp; flushp_w |=> prefetch_flush_out && redirect_out;
  endproperty
  a_flushp: assert property (p_flushp) else $error("no flush");
  property p_sync; sync_w |=> mem_hold_out && busy_out; endproperty
  a_sync: assert property (p_sync) else $error("no hold");
  property p_pend; mem_hold_out && mem_pending_in |=> mem_hold_out && !done_out;
  endproperty
  a_pend: assert property (p_pend) else $error("hold dropped");
  property p_ci_wb; ci_done_in && busy_out |=> wb_valid_out && done_out;
  endproperty
  a_ci_wb: assert property (p_ci_wb) else $error("ci writeback");
  property p_rdprs; rdprs_w |=> busy_out ##1 (done_out && wb_valid_out);
  endproperty
  a_rdprs: assert property (p_rdprs) else $error("prs read");
  property p_plain; plain_w |=> !redirect_out; endproperty
  a_plain: assert property (p_plain) else $error("stray trap");
endmodule // ctl_exc_props

bind ctl_exc_unit ctl_exc_props #(.EXC_ADDR(EXC_ADDR)) i_props (
  .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .issue_in(issue_in),
  .op_in(op_in), .busy_out(busy_out), .done_out(done_out),
  .wb_valid_out(wb_valid_out), .redirect_out(redirect_out),
  .redirect_addr_out(redirect_addr_out),
  .prefetch_flush_out(prefetch_flush_out), .status_out(status_out),
  .mem_pending_in(mem_pending_in), .mem_hold_out(mem_hold_out),
  .ci_done_in(ci_done_in));

// file: test/ci_user_model.sv
// Purpose: custom instruction logic beside the unit
// Assumes: result is a^b^sel after two or five edges
// Notes:   result toggles while not valid
`timescale 1ns/1ns
module ci_user_model (
  input  wire logic        core_clk_in,
  input  wire logic        start_in,
  input  wire logic [7:0]  sel_in,
  input  wire logic [31:0] a_in,
  input  wire logic [31:0] b_in,
  input  wire logic        slow_in,
  output logic             done_out,
  output logic [31:0]      result_out
);
  logic [2:0]  wait_r = 3'h0;
  logic [31:0] res_r;
  initial {done_out, result_out} = '0;
  always @(posedge core_clk_in) begin
    done_out <= wait_r == 3'h1;
    result_out <= wait_r == 3'h1 ? res_r : ~result_out;
    if (start_in) begin
      wait_r <= slow_in ? 3'h5 : 3'h2;
      res_r <= a_in ^ b_in ^ {24'h0, sel_in};
    end else if (wait_r != 3'h0) wait_r <= wait_r - 3'h1;
  end
endmodule // ci_user_model

// file: test/ctl_exc_unit_tb_top.sv
// Purpose: self-checking bench of the control unit
// Assumes: unit parameters at their defaults
// Notes:   custom logic answers fast, then slow
`timescale 1ns/1ns
module ctl_exc_unit_tb_top;
  localparam int RA = 1, WD = 2;
  logic        core_clk_in, rst_b_in, issue_in, busy_out, done_out, slow;
  logic        wb_valid_out, redirect_out, prefetch_flush_out, arith_fwd_out;
  logic        mem_pending_in, mem_hold_out, cache_req_out, cache_ack_in;
  logic        ci_start_out, ci_done_in, reg_wr_in, reg_rd_in, af_f;
  logic [4:0]  ctl_idx_in, dest_idx_in, src_idx_in, wb_dest_out;
  logic [7:0]  ci_sel_in, ci_sel_out, reg_addr_in;
  logic [31:0] opnd_a_in, opnd_b_in, next_pc_in, wb_data_out, redirect_addr_out;
  logic [31:0] status_out, cache_addr_out, ci_dataa_out, ci_datab_out;
  logic [31:0] ci_result_in, reg_wdata_in, reg_rdata_out;
  ctl_exc_pkg::op_t       op_in;
  ctl_exc_pkg::cache_op_t cache_kind_out, kind_seen;
  int          err_count, checks, cyc, n;

  ctl_exc_unit i_dut (.*);
  ci_user_model i_ci (.core_clk_in(core_clk_in), .start_in(ci_start_out),
    .sel_in(ci_sel_out), .a_in(ci_dataa_out), .b_in(ci_datab_out),
    .slow_in(slow), .done_out(ci_done_in), .result_out(ci_result_in));

  initial core_clk_in = 1'b0;
  always #25 core_clk_in = ~core_clk_in;
  // cache acks each request once; watchdog
  always @(posedge core_clk_in) begin
    cache_ack_in <= cache_req_out && !cache_ack_in;
    if (cache_req_out) kind_seen <= cache_kind_out;
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      err_count++;
    end
  endtask
  task automatic finish_test();
    if (err_count == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic reg_acc(input logic wr, input logic [7:0] ad,
                         input logic [31:0] d);
    @(posedge core_clk_in);
    {reg_addr_in, reg_wdata_in, reg_wr_in, reg_rd_in} <= {ad, d, wr, !wr};
    @(posedge core_clk_in);
    {reg_wr_in, reg_rd_in} <= 2'b00;
    #1 if (!wr) chk(reg_rdata_out, d);
  endtask
  task automatic run(input ctl_exc_pkg::op_t op, input logic [31:0] a,
                     input logic [4:0] ix, input int w, input logic [31:0] e);
    @(posedge core_clk_in);
    op_in <= op;
    {opnd_a_in, next_pc_in, ci_sel_in} <= {a, a + 32'h4, a[7:0]};
    {ctl_idx_in, dest_idx_in, src_idx_in} <= {3{ix}};
    issue_in <= 1'b1;
    @(posedge core_clk_in);
    issue_in <= 1'b0;
    n = 0;
    #1 af_f = arith_fwd_out;
    while (done_out !== 1'b1 && n < 60) begin
      @(posedge core_clk_in);
      #1 n++;
      af_f |= arith_fwd_out;
    end
    if (n >= 60) chk(32'h0, 32'h1);
    if (w == RA) chk(redirect_addr_out, e);
    if (w == WD) chk(wb_data_out, e);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {issue_in, mem_pending_in, cache_ack_in, reg_wr_in, reg_rd_in, slow} = '0;
    {ctl_idx_in, dest_idx_in, src_idx_in, ci_sel_in, reg_addr_in} = '0;
    {opnd_a_in, next_pc_in, reg_wdata_in, err_count, checks, cyc} = '0;
    op_in = ctl_exc_pkg::op_nop;
    opnd_b_in = 32'h0F0F_0000;
    rst_b_in = 1'b0;
    repeat (6) @(posedge core_clk_in);
    rst_b_in <= 1'b1;
    reg_acc(1'b0, 8'h00, 32'h0000_00FF);
    reg_acc(1'b1, 8'h0C, 32'h1234_5678);
    reg_acc(1'b0, 8'h0C, 32'h0);
    run(ctl_exc_pkg::op_wrctl, 32'h3, 5'h00, 0, '0);
    run(ctl_exc_pkg::op_trap, 32'h100, '0, RA, 32'h20);
    run(ctl_exc_pkg::op_rdctl, '0, 5'h01, WD, 32'h3);
    run(ctl_exc_pkg::op_rdctl, '0, 5'h03, WD, 32'h104);
    run(ctl_exc_pkg::op_eret, '0, '0, RA, 32'h104);
    run(ctl_exc_pkg::op_rdctl, '0, 5'h00, WD, 32'h3);
    run(ctl_exc_pkg::op_break, 32'h200, '0, RA, 32'h40);
    run(ctl_exc_pkg::op_rdctl, '0, 5'h04, WD, 32'h204);
    run(ctl_exc_pkg::op_bret, '0, '0, RA, 32'h204);
    run(ctl_exc_pkg::op_wrctl, 32'h55, 5'h07, 0, '0);
    run(ctl_exc_pkg::op_rdctl, '0, 5'h07, WD, 32'h0);
    run(ctl_exc_pkg::op_wrctl, 32'h0001_0000, 5'h00, 0, '0);
    run(ctl_exc_pkg::op_wrprs, 32'h0, 5'h00, 0, '0);
    run(ctl_exc_pkg::op_wrprs, 32'hA5, 5'h05, 0, '0);
    run(ctl_exc_pkg::op_rdprs, '0, 5'h00, WD, 32'h0);
    run(ctl_exc_pkg::op_rdprs, '0, 5'h05, WD, 32'hA5);
    chk({27'h0, wb_dest_out}, 32'h5);
    run(ctl_exc_pkg::op_flushp, 32'h300, '0, RA, 32'h304);
    for (int i = 0; i < 6; i++) begin
      run(ctl_exc_pkg::op_t'(int'(ctl_exc_pkg::op_flushd) + i), 32'h400,
          '0, 0, '0);
      chk({29'h0, kind_seen}, 32'(i + 1));
      chk(cache_addr_out, 32'h400);
    end
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      run(ctl_exc_pkg::op_custom, 32'h1234_56C3, '0, WD,
          32'h1234_56C3 ^ 32'h0F0F_0000 ^ 32'hC3);
    end
    reg_acc(1'b1, 8'h00, 32'h0);
    for (int i = 0; i < 8; i++) begin
      run(i < 7 ? ctl_exc_pkg::op_t'(int'(ctl_exc_pkg::op_mul) + i)
          : ctl_exc_pkg::op_initda, 32'h500 + 32'(i * 16), '0, RA,
          32'h20);
    end
    run(ctl_exc_pkg::op_rdctl, '0, 5'h03, WD, 32'h574);
    reg_acc(1'b0, 8'h08, 32'h8);
    reg_acc(1'b1, 8'h00, 32'hFF);
    run(ctl_exc_pkg::op_mul, '0, '0, 0, '0);
    chk({31'h0, af_f}, 32'h1);
    mem_pending_in <= 1'b1;
    fork
      run(ctl_exc_pkg::op_sync, '0, '0, 0, '0);
      begin
        repeat (8) @(posedge core_clk_in);
        mem_pending_in <= 1'b0;
      end
    join
    chk({31'h0, n > 5}, 32'h1);
    finish_test();
  end
endmodule // ctl_exc_unit_tb_top
